// ---- hw/stack_limit_regs.svh ----
// Constants for the stack pointer and stack bounds checker.
// Assumes inclusion by bare name from the package or modules.
`ifndef STACK_LIMIT_REGS_SVH
`define STACK_LIMIT_REGS_SVH

// ----------------------------------------------------------------
// Lower bound, reset value, word step and alignment bit
// ----------------------------------------------------------------
`define STK_LOWER_BOUND 16'h0800
`define STK_PTR_RESET 16'h0800
`define STK_WORD_STEP 16'h0002
`define STK_ALIGN_BIT 0

`endif

// ---- hw/stack_limit_pkg.sv ----
// Types shared by the stack bounds checker.
// Assumes the constants header sits beside it.
`include "stack_limit_regs.svh"

package stack_limit_pkg;

    // Stack access kinds requested by the core
    typedef enum logic [2:0] {
        OP_NONE,
        OP_PUSH,
        OP_POP,
        OP_CALL_PUSH,
        OP_EXC_PUSH,
        OP_INDIRECT
    } stack_op_e;

    // One request from address generation
    typedef struct packed {
        stack_op_e op;
        logic [15:0] offset;
        logic [7:0] pc_high;
        logic [7:0] status_low_byte;
    } stack_req_s;

    // Result handed back to the core
    typedef struct packed {
        logic [15:0] effective_address;
        logic [15:0] push_word;
        logic write;
        logic read;
        logic trap;
        logic overflow;
        logic underflow;
    } stack_rsp_s;

endpackage : stack_limit_pkg

// ---- hw/stack_limit_checker.sv ----
// Stack pointer update and stack limit checking beside address generation.
// Assumes the core drives one request per cycle on the same clock and
// takes the trap request as a one-cycle pulse into its exception logic.
// The limit has no reset value, so the core writes it before any push.
// Every response field is combinational and stands for the request cycle.
//
// Operation
// - Pointer serves as working register too
// - Pointer addresses next free word, grows upward
// - Push writes then increments; pop decrements then reads
// - Call push zeroes top byte of upper word
// - Exception push puts status byte on top
// - Limit register holds top bound, reset-free
// - Limit bit zero always reads zero
// - Every pointer-based address compared against limit
// - Push at limit passes; next one traps
// - Pointer-based address below 0x0800 raises underflow trap
`timescale 1ns/10ps
`include "stack_limit_regs.svh"

module stack_limit_checker
    import stack_limit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input stack_req_s req,
    input wire logic wreg_we,
    input wire logic [15:0] wreg_wdata,
    input wire logic limit_we,
    input wire logic [15:0] limit_wdata,
    output logic [15:0] stack_pointer,
    output logic [15:0] limit_value,
    output stack_rsp_s rsp
);

    // ----------------------------------------------------------------
    // Pointer and limit state
    // ----------------------------------------------------------------
    logic [15:0] sp_q, sp_d;
    logic [15:0] lim_q, lim_d;
    logic [15:0] ea;
    logic is_push, is_pop, ovf, unf;
    stack_rsp_s rsp_d;

    // Push kinds share the write-then-increment order
    function automatic logic push_kind(input stack_op_e op);
        return (op == OP_PUSH) || (op == OP_CALL_PUSH) || (op == OP_EXC_PUSH);
    endfunction : push_kind

    // Address above the upper bound of the stack
    function automatic logic above_bound(input logic [15:0] addr, input logic [15:0] bound);
        return addr > bound;
    endfunction : above_bound

    assign is_push = push_kind(req.op);
    assign is_pop = (req.op == OP_POP);

    // ----------------------------------------------------------------
    // Address formation and bounds
    // ----------------------------------------------------------------
    // Address formation from the pointer
    always_comb begin
        if (is_push) begin
            ea = sp_q;
        end else if (is_pop) begin
            ea = sp_q - `STK_WORD_STEP;
        end else begin
            ea = sp_q + req.offset;
        end
    end

    // Bounds checks on every pointer-based address
    always_comb begin
        ovf = 1'b0;
        unf = 1'b0;
        if (req.op != OP_NONE) begin
            ovf = is_push ? above_bound(sp_q, lim_q) : above_bound(ea, lim_q);
            unf = (ea < `STK_LOWER_BOUND);
        end
    end

    // ----------------------------------------------------------------
    // Next state and response
    // ----------------------------------------------------------------
    // Next pointer and limit values
    always_comb begin
        sp_d = sp_q;
        lim_d = lim_q;
        if (wreg_we) begin
            sp_d = wreg_wdata;
        end else if (is_push) begin
            sp_d = sp_q + `STK_WORD_STEP;
        end else if (is_pop) begin
            sp_d = sp_q - `STK_WORD_STEP;
        end
        sp_d[`STK_ALIGN_BIT] = 1'b0;
        if (limit_we) begin
            lim_d = limit_wdata;
        end
        lim_d[`STK_ALIGN_BIT] = 1'b0;
    end

    // Response word and trap
    always_comb begin
        rsp_d = '0;
        rsp_d.effective_address = ea;
        rsp_d.write = is_push;
        rsp_d.read = is_pop;
        rsp_d.overflow = ovf;
        rsp_d.underflow = unf;
        rsp_d.trap = ovf | unf;
        case (req.op)
            OP_CALL_PUSH: rsp_d.push_word = {8'h00, req.pc_high};
            OP_EXC_PUSH: rsp_d.push_word = {req.status_low_byte, req.pc_high};
            default: rsp_d.push_word = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Pointer resets; limit holds no reset value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp_q <= `STK_PTR_RESET;
        end else begin
            sp_q <= sp_d;
        end
    end

    // Limit register, deliberately left uninitialised
    always_ff @(posedge clk) begin
        lim_q <= lim_d;
    end

    assign stack_pointer = sp_q;
    assign limit_value = lim_q;
    assign rsp = rsp_d;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Pointer movement and reset
    a_push_advance: assert property (is_push && !wreg_we
            |=> sp_q == $past(sp_q) + `STK_WORD_STEP)
        else $error("push did not advance pointer");
    a_pop_retreat: assert property (is_pop && !wreg_we
            |=> sp_q == $past(sp_q) - `STK_WORD_STEP)
        else $error("pop did not retreat pointer");
    a_sp_hold: assert property (!is_push && !is_pop && !wreg_we
            |=> sp_q == $past(sp_q))
        else $error("pointer moved without push or pop");
    a_sp_align: assert property (stack_pointer[`STK_ALIGN_BIT] == 1'b0)
        else $error("pointer not word aligned");
    a_wreg_write: assert property (wreg_we
            |=> stack_pointer == ($past(wreg_wdata) & 16'hfffe))
        else $error("working write lost");
    a_reset_value: assert property (disable iff (1'b0) !rst_n
            |=> stack_pointer == `STK_PTR_RESET)
        else $error("pointer reset value wrong");

    // Addresses formed from the pointer
    a_push_addr: assert property (is_push |-> rsp.effective_address == sp_q)
        else $error("push address not current pointer");
    a_pop_addr: assert property (is_pop
            |-> rsp.effective_address == sp_q - `STK_WORD_STEP)
        else $error("pop address not below pointer");
    a_indirect_addr: assert property (req.op == OP_INDIRECT
            |-> rsp.effective_address == sp_q + req.offset)
        else $error("indirect address not pointer plus offset");
    a_no_access: assert property (!is_push && !is_pop
            |-> !rsp.write && !rsp.read)
        else $error("memory access without push or pop");

    // Program counter words
    a_call_zero: assert property (req.op == OP_CALL_PUSH |-> rsp.push_word[15:8] == 8'h00)
        else $error("call push top byte not zero");
    a_exc_status: assert property (req.op == OP_EXC_PUSH
            |-> rsp.push_word[15:8] == req.status_low_byte)
        else $error("exception push lacks status byte");
    a_pc_low: assert property (req.op == OP_CALL_PUSH || req.op == OP_EXC_PUSH
            |-> rsp.push_word[7:0] == req.pc_high)
        else $error("pushed word lost program counter byte");

    // Limit register and bounds
    a_limit_align: assert property (limit_we |=> limit_value[0] == 1'b0)
        else $error("limit bit zero set");
    a_limit_load: assert property (limit_we
            |=> limit_value == ($past(limit_wdata) & 16'hfffe))
        else $error("limit write lost");
    a_at_limit: assert property (is_push && sp_q == limit_value
            && sp_q >= `STK_LOWER_BOUND |-> !rsp.trap)
        else $error("push at limit trapped");
    a_beyond_limit: assert property (is_push && sp_q > limit_value |-> rsp.trap)
        else $error("push beyond limit missed");
    a_other_limit: assert property (is_pop || req.op == OP_INDIRECT
            |-> rsp.overflow == (rsp.effective_address > limit_value))
        else $error("pointer address not compared with limit");

    // Underflow and the single trap request
    a_under_trap: assert property (req.op != OP_NONE && rsp.effective_address < `STK_LOWER_BOUND
            |-> rsp.trap && rsp.underflow)
        else $error("underflow not trapped");
    a_trap_cause: assert property (rsp.trap |-> rsp.overflow || rsp.underflow)
        else $error("trap without cause");
    a_trap_sum: assert property (rsp.overflow || rsp.underflow |-> rsp.trap)
        else $error("error detected without trap");
    a_idle_quiet: assert property (req.op == OP_NONE |-> !rsp.trap)
        else $error("trap without a pointer address");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    c_push: cover property (is_push ##1 is_push);
    c_pop: cover property (is_push ##1 is_pop);
    c_overflow: cover property (rsp.overflow);
    c_underflow: cover property (rsp.underflow);
    c_indirect: cover property (req.op == OP_INDIRECT && rsp.trap);

endmodule : stack_limit_checker

// ---- tb/core_trap_model.sv ----
// Core-side stub that takes the stack error trap requests.
// Assumes the checker's response settles within the request cycle.
`timescale 1ns/10ps

module core_trap_model
    import stack_limit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input stack_rsp_s rsp,
    output int trap_count
);
    // Counts trap requests; stimulus never reads through the pointer
    // in the cycle after a limit write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trap_count <= 0;
        end else if (rsp.trap === 1'b1) begin
            trap_count <= trap_count + 1;
        end
    end
endmodule : core_trap_model

// ---- tb/stack_limit_checker_tb_top.sv ----
// Self-checking bench for the stack bounds checker.
// Assumes one request per cycle and a combinational response.
`timescale 1ns/10ps

module stack_limit_checker_tb_top;
    import stack_limit_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic wreg_we = 0;
    logic limit_we = 0;
    logic [15:0] wreg_wdata = '0;
    logic [15:0] limit_wdata = '0;
    logic [15:0] stack_pointer, limit_value, sp, lim;
    stack_req_s req = '0;
    stack_rsp_s rsp;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int traps = 0;
    int trap_seen;

    stack_limit_checker stack_limit_checker_i (.clk(clk), .rst_n(rst_n), .req(req),
        .wreg_we(wreg_we), .wreg_wdata(wreg_wdata), .limit_we(limit_we),
        .limit_wdata(limit_wdata), .stack_pointer(stack_pointer),
        .limit_value(limit_value), .rsp(rsp));
    core_trap_model core_trap_model_i (.clk(clk), .rst_n(rst_n), .rsp(rsp),
        .trap_count(trap_seen));

    // Clock and hang guard
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    // Writes pointer and limit together
    task automatic load(logic [15:0] s, logic [15:0] l);
        @(posedge clk);
        req <= '0;
        wreg_we <= 1'b1;
        wreg_wdata <= s;
        limit_we <= 1'b1;
        limit_wdata <= l;
        @(posedge clk);
        wreg_we <= 1'b0;
        limit_we <= 1'b0;
        sp = s & 16'hfffe;
        lim = l & 16'hfffe;
        #1;
        check("sp", stack_pointer, sp);
        check("lim", limit_value, lim);
    endtask : load

    // One stack request, response checked within its cycle
    task automatic do_op(stack_op_e op, logic [15:0] off, logic [7:0] pc, logic [7:0] sl);
        logic [15:0] ea;
        logic push;
        push = op inside {OP_PUSH, OP_CALL_PUSH, OP_EXC_PUSH};
        ea = (op == OP_POP) ? sp - 16'h0002 : (op == OP_INDIRECT) ? sp + off : sp;
        @(posedge clk);
        req <= '{op, off, pc, sl};
        #1;
        check("sp", stack_pointer, sp);
        check("ea", rsp.effective_address, ea);
        check("wr", 16'(rsp.write), 16'(push));
        check("rd", 16'(rsp.read), 16'(op == OP_POP));
        check("ovf", 16'(rsp.overflow), 16'(ea > lim));
        check("udf", 16'(rsp.underflow), 16'(ea < 16'h0800));
        check("trap", 16'(rsp.trap), 16'(ea > lim || ea < 16'h0800));
        if (op == OP_CALL_PUSH) check("word", rsp.push_word, {8'h00, pc});
        if (op == OP_EXC_PUSH) check("word", rsp.push_word, {sl, pc});
        if (ea > lim || ea < 16'h0800) traps++;
        sp = (op == OP_POP) ? ea : push ? sp + 16'h0002 : sp;
    endtask : do_op

    // Main sequence
    initial begin
        void'($urandom(79775));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        load(16'h0800, 16'h0805);
        repeat (4) do_op(OP_PUSH, 16'h0000, 8'h00, 8'h00);
        repeat (5) do_op(OP_POP, 16'h0000, 8'h00, 8'h00);
        $display("test walk done");
        // Reset in mid-run: pointer restarts, limit keeps its value
        @(posedge clk);
        req <= '0;
        rst_n <= 1'b0;
        #1;
        check("traps", 16'(trap_seen), 16'(traps));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        traps = 0;
        sp = 16'h0800;
        check("sp rst", stack_pointer, sp);
        check("lim rst", limit_value, lim);
        do_op(OP_PUSH, 16'h0000, 8'h00, 8'h00);
        $display("test reset done");
        // Limit writes leave an idle cycle before any indirect request
        load(16'h0901, 16'h0a00);
        do_op(OP_CALL_PUSH, 16'h0000, 8'(~8'h00), 8'h5a);
        do_op(OP_EXC_PUSH, 16'h0000, 8'(~8'h00), 8'ha5);
        do_op(OP_INDIRECT, 16'h00fc, 8'h00, 8'h00);
        do_op(OP_INDIRECT, 16'h00fe, 8'h00, 8'h00);
        do_op(OP_INDIRECT, 16'hfefc, 8'h00, 8'h00);
        do_op(OP_INDIRECT, 16'hfefa, 8'h00, 8'h00);
        $display("test indirect done");
        repeat (300) do_op(stack_op_e'($urandom_range(1, 5)),
            16'($urandom_range(0, 511)) - 16'h0100, 8'($urandom), 8'($urandom));
        $display("test random done");
        @(posedge clk);
        req <= '0;
        #1;
        check("sp end", stack_pointer, sp);
        check("traps", 16'(trap_seen), 16'(traps));
        final_report();
    end
endmodule : stack_limit_checker_tb_top
